/* File: dv/tb_top.sv */
// Self-checking bench for the audio clock source select block.
// Assumes the register port contract of the block: strobes taken on clk rise.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import clk_src_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals, model state and counters
    // ------------------------------------------------------------------
    logic       clk;
    logic       rst;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    src_vec_t   pre;
    src_vec_t   pri;
    src_vec_t   sec;
    logic       bad;
    logic [7:0] m32;
    logic [7:0] m33;
    logic [7:0] d;
    int         miscompares = 0;
    int         total_checks = 0;
    int         cycles = 0;
    int         pre_map [0:3] = '{SRC_PRIMARY, SRC_SECONDARY, SRC_CTRL, SRC_OSC};
    int         div_map [0:5] = '{SRC_PLL, SRC_PRIMARY, SRC_SECONDARY, SRC_CTRL, SRC_OSC, SRC_DSP};

    audio_clock_source_select DUT (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .prescaler_input_clock(pre), .primary_bitclk_divider_source(pri),
        .secondary_bitclk_divider_source(sec), .source_code_reserved(bad)
    );

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Reference model and bus tasks
    // ------------------------------------------------------------------
    // Reserved divider codes select nothing, so the model returns an empty vector.
    function automatic logic [5:0] exp_div(input logic [2:0] c, input logic [2:0] rsv);
        if (c == rsv || c > 3'h5) begin
            return 6'h00;
        end
        return 6'h01 << div_map[c];
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write strobe stands for exactly one taking edge; the model keeps writable bits only.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == 8'h32) m32 = v & 8'hf8;
        if (a == 8'h33) m33 = v & 8'h70;
    endtask

    // The answer is awaited for a few cycles only, so a missing pulse cannot hang the run.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        while (reg_rvalid !== 1'b1 && n < 3) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
        v = reg_rdata;
    endtask

    // Outputs settle two edges after the write; they are then compared with the model.
    task automatic check_all();
        repeat (2) @(posedge clk);
        #1;
        chk("prescaler", {2'h0, 6'h01 << pre_map[m32[7:6]]}, {2'h0, pre});
        chk("primary", {2'h0, exp_div(m32[5:3], 3'h1)}, {2'h0, pri});
        chk("secondary", {2'h0, exp_div(m33[6:4], 3'h2)}, {2'h0, sec});
        chk("reserved_flag", {7'h0, m32[5:3] inside {1, 6, 7} || m33[6:4] inside {2, 6, 7}},
            {7'h0, bad});
        rd(8'h32, d);
        chk("reg_32", m32, d);
        rd(8'h33, d);
        chk("reg_33", m33, d);
    endtask

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    // Ceiling on run length, far above the few hundred cycles the tests need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        m32 = 8'h00;
        m33 = 8'h00;
        void'($urandom(32'hc354));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        check_all();
        // Every prescaler code against every primary code, secondary code rotated along,
        // with random junk in reserved bits and two writes one idle cycle apart. The bench acts
        // as a host in custom clock configuration, so oscillator codes are legal here.
        for (int p = 0; p < 4; p++) begin
            for (int q = 0; q < 8; q++) begin
                wr(8'h32, {p[1:0], q[2:0], 3'($urandom)});
                wr(8'h33, {1'($urandom), 3'((p + q) % 8), 4'($urandom)});
                check_all();
            end
        end
        // Unmapped places ignore writes and read as zero.
        wr(8'h34, 8'hff);
        wr(8'h31, 8'hff);
        rd(8'h34, d);
        chk("unmapped_34", 8'h00, d);
        rd(8'h31, d);
        chk("unmapped_31", 8'h00, d);
        check_all();
        // Reset in mid-run returns every select to its power-up source.
        @(posedge clk);
        rst <= 1'b1;
        m32 = 8'h00;
        m33 = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_all();
        stop_test();
    end
endmodule

`default_nettype wire

/* File: hdl/audio_clock_source_select.sv */
// Two clock source registers of an audio converter and the one-hot source
// selects they drive for the PLL prescaler and both bit-clock dividers.
// Assumes a control interface that issues one-cycle write and read strobes
// with an 8-bit register address on clk.
`timescale 1ns/1ps
`default_nettype none
`include "clk_src_cfg.svh"

module audio_clock_source_select
    import clk_src_pkg::*;
(
    input  wire logic       clk,              // Block clock, 250 MHz.
    input  wire logic       rst,              // Asynchronous reset, high.
    input  wire logic       reg_wr,           // Write strobe, one cycle.
    input  wire logic       reg_rd,           // Read strobe, one cycle.
    input  wire logic [7:0] reg_addr,         // Register address.
    input  wire logic [7:0] reg_wdata,        // Write data.
    output var  logic [7:0] reg_rdata,        // Read data, registered.
    output var  logic       reg_rvalid,       // Read data valid pulse.
    output var  src_vec_t   prescaler_input_clock,          // Prescaler source.
    output var  src_vec_t   primary_bitclk_divider_source,  // Primary source.
    output var  src_vec_t   secondary_bitclk_divider_source,// Secondary source.
    output var  logic       source_code_reserved            // Reserved code held.
);

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    logic [7:0] pre_pri_ff, nxt_pre_pri;
    logic [7:0] sec_ff,     nxt_sec;
    logic [7:0] rdata_ff,   nxt_rdata;
    logic       rvalid_ff,  nxt_rvalid;

    // Writes keep only the writable bits, so reserved bits stay zero even
    // when software breaks the write-reset-value convention.
    always_comb begin
        nxt_pre_pri = pre_pri_ff;
        nxt_sec     = sec_ff;
        if (reg_wr && reg_addr == `CS_ADDR_PRE_PRI) begin
            nxt_pre_pri = reg_wdata & `CS_MASK_PRE_PRI;
        end else if (reg_wr && reg_addr == `CS_ADDR_SEC) begin
            nxt_sec = reg_wdata & `CS_MASK_SEC;
        end
    end

    // Read path; an unmapped address answers zero.
    always_comb begin
        nxt_rvalid = reg_rd;
        nxt_rdata  = 8'h00;
        if (reg_rd && reg_addr == `CS_ADDR_PRE_PRI) begin
            nxt_rdata = pre_pri_ff;
        end else if (reg_rd && reg_addr == `CS_ADDR_SEC) begin
            nxt_rdata = sec_ff;
        end
    end

    // Both registers reset to zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_pri_ff <= `CS_RESET_VAL;
            sec_ff     <= `CS_RESET_VAL;
            rdata_ff   <= 8'h00;
            rvalid_ff  <= 1'b0;
        end else begin
            pre_pri_ff <= nxt_pre_pri;
            sec_ff     <= nxt_sec;
            rdata_ff   <= nxt_rdata;
            rvalid_ff  <= nxt_rvalid;
        end
    end

    assign reg_rdata  = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // ------------------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------------------
    // Selection is one cycle behind the register, which costs nothing since
    // a clock source change needs the PLL or divider restarted anyway.
    clk_src_decode u_decode (
        .clk      (clk),
        .rst      (rst),
        .pre_code (pre_pri_ff[`CS_PRE_MSB:`CS_PRE_LSB]),
        .pri_code (pre_pri_ff[`CS_PRI_MSB:`CS_PRI_LSB]),
        .sec_code (sec_ff[`CS_SEC_MSB:`CS_SEC_LSB]),
        .pre_sel  (prescaler_input_clock),
        .pri_sel  (primary_bitclk_divider_source),
        .sec_sel  (secondary_bitclk_divider_source),
        .code_bad (source_code_reserved)
    );

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Helper: a write to each register in the current cycle, and the stored fields.
    logic       wr_pp, wr_sc;
    logic [1:0] pre_field;
    logic [2:0] pri_field, sec_field;
    assign wr_pp     = reg_wr && reg_addr == `CS_ADDR_PRE_PRI;
    assign wr_sc     = reg_wr && reg_addr == `CS_ADDR_SEC;
    assign pre_field = pre_pri_ff[`CS_PRE_MSB:`CS_PRE_LSB];
    assign pri_field = pre_pri_ff[`CS_PRI_MSB:`CS_PRI_LSB];
    assign sec_field = sec_ff[`CS_SEC_MSB:`CS_SEC_LSB];

    reserved_bits_zero_a: assert property (
        pre_pri_ff[2:0] == 3'h0 && sec_ff[7] == 1'b0 && sec_ff[3:0] == 4'h0)
        else $error("Reserved clock source bits are not zero.");

    write_store_a: assert property (
        wr_pp |=> pre_pri_ff == ($past(reg_wdata) & `CS_MASK_PRE_PRI))
        else $error("Prescaler and primary register did not store the write.");

    read_back_a: assert property (
        reg_rd && reg_addr == `CS_ADDR_SEC && !wr_sc
        ##1 !reg_wr [*1] |-> reg_rvalid && reg_rdata == sec_ff)
        else $error("Secondary register read back is wrong.");

    prescaler_ctrl_a: assert property (
        wr_pp && reg_wdata[7:6] == `CS_PRE_CTRL ##1 !wr_pp
        |=> prescaler_input_clock == src_vec_t'(6'h08))
        else $error("Prescaler does not take the controller clock.");

    prescaler_osc_a: assert property (
        pre_pri_ff[7:6] == `CS_PRE_OSC |=> prescaler_input_clock[SRC_OSC])
        else $error("Prescaler does not take the internal oscillator.");

    primary_dsp_a: assert property (
        wr_pp && reg_wdata[5:3] == `CS_DIV_DSP ##1 !wr_pp
        |=> primary_bitclk_divider_source == src_vec_t'(6'h20))
        else $error("Primary divider does not take the DSP clock.");

    primary_reserved_a: assert property (
        pre_pri_ff[5:3] == `CS_DIV_PRIMARY
        |=> primary_bitclk_divider_source == '0 && source_code_reserved)
        else $error("Primary reserved code selected a source.");

    secondary_map_a: assert property (
        sec_ff[6:4] == `CS_DIV_PRIMARY
        |=> secondary_bitclk_divider_source == src_vec_t'(6'h02))
        else $error("Secondary divider does not take the primary bit clock.");

    secondary_reserved_a: assert property (
        sec_ff[6:4] == `CS_DIV_SECONDARY |=> secondary_bitclk_divider_source == '0)
        else $error("Secondary reserved code selected a source.");

    reset_default_a: assert property (
        $fell(rst) |-> prescaler_input_clock == src_vec_t'(6'h02)
        && primary_bitclk_divider_source == src_vec_t'(6'h01)
        && secondary_bitclk_divider_source == src_vec_t'(6'h01))
        else $error("Sources after reset are not the defaults.");

    sec_write_store_a: assert property (
        wr_sc |=> sec_ff == ($past(reg_wdata) & `CS_MASK_SEC))
        else $error("Secondary register did not store the write.");

    read_back_pri_a: assert property (
        reg_rd && reg_addr == `CS_ADDR_PRE_PRI && !wr_pp
        |=> reg_rvalid && reg_rdata == pre_pri_ff)
        else $error("Prescaler and primary register read back is wrong.");

    // ------------------------------------------------------------------------
    // Decode map: one-hot checks and the source codes not asserted above
    // ------------------------------------------------------------------------
    // Each map check looks at the stored field, so writes and resets are both
    // covered; the decode register shows the answer one edge later.
    prescaler_onehot_a: assert property (
        $onehot(prescaler_input_clock))
        else $error("Prescaler select is not one-hot.");

    prescaler_primary_a: assert property (
        pre_field == `CS_PRE_PRIMARY
        |=> prescaler_input_clock == src_vec_t'(6'h02))
        else $error("Prescaler does not take the primary bit clock.");

    prescaler_secondary_a: assert property (
        pre_field == `CS_PRE_SECONDARY
        |=> prescaler_input_clock == src_vec_t'(6'h04))
        else $error("Prescaler does not take the secondary bit clock.");

    // While neither divider holds a reserved code, both must be fed from exactly one source.
    divider_onehot_a: assert property (
        !source_code_reserved |-> $onehot(primary_bitclk_divider_source)
        && $onehot(secondary_bitclk_divider_source))
        else $error("Divider select is not one-hot.");

    primary_pll_a: assert property (
        pri_field == `CS_DIV_PLL
        |=> primary_bitclk_divider_source == src_vec_t'(6'h01))
        else $error("Primary divider does not take the PLL output.");

    primary_secondary_a: assert property (
        pri_field == `CS_DIV_SECONDARY
        |=> primary_bitclk_divider_source == src_vec_t'(6'h04))
        else $error("Primary divider does not take the secondary bit clock.");

    primary_ctrl_a: assert property (
        pri_field == `CS_DIV_CTRL
        |=> primary_bitclk_divider_source == src_vec_t'(6'h08))
        else $error("Primary divider does not take the controller clock.");

    primary_osc_a: assert property (
        pri_field == `CS_DIV_OSC
        |=> primary_bitclk_divider_source == src_vec_t'(6'h10))
        else $error("Primary divider does not take the internal oscillator.");

    primary_high_a: assert property (
        pri_field > `CS_DIV_DSP
        |=> primary_bitclk_divider_source == '0 && source_code_reserved)
        else $error("Primary high reserved code selected a source.");

    secondary_pll_a: assert property (
        sec_field == `CS_DIV_PLL
        |=> secondary_bitclk_divider_source == src_vec_t'(6'h01))
        else $error("Secondary divider does not take the PLL output.");

    secondary_ctrl_a: assert property (
        sec_field == `CS_DIV_CTRL
        |=> secondary_bitclk_divider_source == src_vec_t'(6'h08))
        else $error("Secondary divider does not take the controller clock.");

    secondary_osc_a: assert property (
        sec_field == `CS_DIV_OSC
        |=> secondary_bitclk_divider_source == src_vec_t'(6'h10))
        else $error("Secondary divider does not take the internal oscillator.");

    secondary_dsp_a: assert property (
        sec_field == `CS_DIV_DSP
        |=> secondary_bitclk_divider_source == src_vec_t'(6'h20))
        else $error("Secondary divider does not take the DSP clock.");

    secondary_high_a: assert property (
        sec_field > `CS_DIV_DSP
        |=> secondary_bitclk_divider_source == '0 && source_code_reserved)
        else $error("Secondary high reserved code selected a source.");

    cover_pre_sec_c:  cover property (wr_pp ##2 prescaler_input_clock[SRC_SECONDARY]);
    cover_sec_osc_c:  cover property (wr_sc ##2 secondary_bitclk_divider_source[SRC_OSC]);
    cover_read_c:     cover property (reg_rd ##1 reg_rvalid && reg_rdata != 8'h00);
    cover_pri_dsp_c:  cover property (wr_pp ##2 primary_bitclk_divider_source[SRC_DSP]);
    cover_reserved_c: cover property (wr_sc ##2 source_code_reserved);

endmodule

`default_nettype wire

/* File: hdl/clk_src_cfg.svh */
// Register offsets, field positions, reset values and source codes of the
// audio clock source selection block. Included by its bare name.
//
// Function
// - Prescaler source field bits 7-6: primary, secondary, controller clock, oscillator.
// - Primary divider source bits 5-3: PLL, -, secondary, controller, oscillator, DSP.
// - Secondary divider source bits 6-4: PLL, primary, -, controller, oscillator, DSP.
// - Both registers reset to zero: prescaler from primary, dividers from PLL.
`ifndef CLK_SRC_CFG_SVH
`define CLK_SRC_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CS_ADDR_PRE_PRI   8'h32
`define CS_ADDR_SEC       8'h33
`define CS_RESET_VAL      8'h00

// One-hot selects after reset: prescaler on the primary bit clock, dividers on PLL.
`define CS_RST_PRE_SEL    6'h02
`define CS_RST_DIV_SEL    6'h01

// ----------------------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------------------
`define CS_PRE_MSB        7
`define CS_PRE_LSB        6
`define CS_PRI_MSB        5
`define CS_PRI_LSB        3
`define CS_SEC_MSB        6
`define CS_SEC_LSB        4
`define CS_MASK_PRE_PRI   8'hf8
`define CS_MASK_SEC       8'h70

// ----------------------------------------------------------------------------
// Source codes
// ----------------------------------------------------------------------------
`define CS_PRE_PRIMARY    2'h0
`define CS_PRE_SECONDARY  2'h1
`define CS_PRE_CTRL       2'h2
`define CS_PRE_OSC        2'h3
`define CS_DIV_PLL        3'h0
`define CS_DIV_PRIMARY    3'h1
`define CS_DIV_SECONDARY  3'h2
`define CS_DIV_CTRL       3'h3
`define CS_DIV_OSC        3'h4
`define CS_DIV_DSP        3'h5

`endif

/* File: hdl/clk_src_decode.sv */
// Decoder from the stored source codes to registered one-hot source selects.
// Assumes the codes come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "clk_src_cfg.svh"

module clk_src_decode
    import clk_src_pkg::*;
(
    input  wire logic                 clk,          // Block clock.
    input  wire logic                 rst,          // Asynchronous reset, high.
    input  wire logic [1:0]           pre_code,     // Prescaler source code.
    input  wire logic [2:0]           pri_code,     // Primary divider code.
    input  wire logic [2:0]           sec_code,     // Secondary divider code.
    output var  src_vec_t             pre_sel,      // Prescaler one-hot select.
    output var  src_vec_t             pri_sel,      // Primary one-hot select.
    output var  src_vec_t             sec_sel,      // Secondary one-hot select.
    output var  logic                 code_bad      // A reserved code is held.
);

    src_vec_t pre_sel_ff, nxt_pre_sel;
    src_vec_t pri_sel_ff, nxt_pri_sel;
    src_vec_t sec_sel_ff, nxt_sec_sel;
    logic     code_bad_ff, nxt_code_bad;

    // Divider code to one-hot; a reserved code selects nothing so that no
    // clock runs into a divider from an undefined source.
    function automatic src_vec_t div_decode(input logic [2:0] code, input logic is_pri);
        src_vec_t v;
        v = '0;
        case (code)
            `CS_DIV_PLL:       v[SRC_PLL] = 1'b1;
            `CS_DIV_PRIMARY:   v[SRC_PRIMARY] = !is_pri;
            `CS_DIV_SECONDARY: v[SRC_SECONDARY] = is_pri;
            `CS_DIV_CTRL:      v[SRC_CTRL] = 1'b1;
            `CS_DIV_OSC:       v[SRC_OSC] = 1'b1;
            `CS_DIV_DSP:       v[SRC_DSP] = 1'b1;
            default:           v = '0;
        endcase
        return v;
    endfunction

    // Next selects for all three destinations.
    always_comb begin
        nxt_pre_sel = '0;
        case (pre_code)
            `CS_PRE_PRIMARY:   nxt_pre_sel[SRC_PRIMARY] = 1'b1;
            `CS_PRE_SECONDARY: nxt_pre_sel[SRC_SECONDARY] = 1'b1;
            `CS_PRE_CTRL:      nxt_pre_sel[SRC_CTRL] = 1'b1;
            default:           nxt_pre_sel[SRC_OSC] = 1'b1;
        endcase
        nxt_pri_sel  = div_decode(pri_code, 1'b1);
        nxt_sec_sel  = div_decode(sec_code, 1'b0);
        nxt_code_bad = (nxt_pri_sel == '0) || (nxt_sec_sel == '0);
    end

    // Reset leaves the prescaler on the primary bit clock, dividers on PLL.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_sel_ff  <= src_vec_t'(`CS_RST_PRE_SEL);
            pri_sel_ff  <= src_vec_t'(`CS_RST_DIV_SEL);
            sec_sel_ff  <= src_vec_t'(`CS_RST_DIV_SEL);
            code_bad_ff <= 1'b0;
        end else begin
            pre_sel_ff  <= nxt_pre_sel;
            pri_sel_ff  <= nxt_pri_sel;
            sec_sel_ff  <= nxt_sec_sel;
            code_bad_ff <= nxt_code_bad;
        end
    end

    assign pre_sel  = pre_sel_ff;
    assign pri_sel  = pri_sel_ff;
    assign sec_sel  = sec_sel_ff;
    assign code_bad = code_bad_ff;

endmodule

`default_nettype wire

/* File: hdl/clk_src_pkg.sv */
// Types shared by the clock source selection files.
// Assumes the one-hot source order below is used by every consumer.
package clk_src_pkg;

    // Bit index of each candidate source inside a one-hot source vector.
    typedef enum {
        SRC_PLL,
        SRC_PRIMARY,
        SRC_SECONDARY,
        SRC_CTRL,
        SRC_OSC,
        SRC_DSP,
        SRC_COUNT
    } src_idx_t;

    typedef logic [SRC_COUNT-1:0] src_vec_t;

endpackage
